// *** shared/cnt_pkg.sv ***
// Package for the CAN timing, enable and interrupt control block
package cnt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TIMING  = 8'h04;
    localparam logic [7:0] OFS_ERRCNT  = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_CAUSE   = 8'h10;
    localparam logic [7:0] OFS_CLEAR   = 8'h14;
    localparam logic [7:0] OFS_OBJPEND = 8'h18;
    localparam logic [7:0] OFS_OBJTXEN = 8'h1C;
    localparam logic [7:0] OFS_OBJRXEN = 8'h20;
    localparam logic [7:0] OFS_BITPOS  = 8'h24;

    // Control register bit positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_IE_BIT     = 1;
    localparam int CTRL_SIE_BIT    = 2;
    localparam int CTRL_EIE_BIT    = 3;

    // Status register bit positions
    localparam int STS_TXOK_BIT    = 3;
    localparam int STS_RXOK_BIT    = 4;
    localparam int STS_EPASS_BIT   = 5;
    localparam int STS_EWARN_BIT   = 6;
    localparam int STS_BOFF_BIT    = 7;

    // Reset and limit values
    localparam logic [31:0] TIMING_RESET     = 32'h0000_2301;
    localparam logic [7:0]  ERR_PASSIVE_LIM  = 8'h80;
    localparam logic [7:0]  ERR_WARN_LIM     = 8'h60;
    localparam logic [8:0]  BUS_OFF_LIM      = 9'h100;
    localparam logic [15:0] STATUS_CAUSE     = 16'h8000;
    localparam int          NUM_OBJ          = 32;

    // Bit-timing fields, same layout on write and read
    typedef struct packed {
        logic [16:0] rsvd;
        logic [2:0]  second_segment_quanta;
        logic [3:0]  first_segment_quanta;
        logic [1:0]  resync_jump_width;
        logic [5:0]  quantum_divisor;
    } cnt_timing_t;

    // Events coming from the protocol engine
    typedef struct packed {
        logic        tx_ok;
        logic        rx_ok;
        logic [2:0]  lec;
        logic        obj_done;
        logic [4:0]  obj_idx;
        logic        obj_read;
        logic [4:0]  obj_read_idx;
        logic        tx_err_inc;
        logic        rx_err_inc;
        logic        err_dec;
    } cnt_evt_t;

    typedef enum logic [2:0] {
        SEG_SYNC  = 3'b001,
        SEG_FIRST = 3'b010,
        SEG_SECND = 3'b100
    } cnt_seg_t;
endpackage : cnt_pkg

// *** hw/cnt_quantum.sv ***
// Quantum divider and bit segment sequencer
`timescale 1ns/1ps
`default_nettype none
module cnt_quantum (
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_run,
    input  wire cnt_pkg::cnt_timing_t i_timing,
    output logic                    o_bit_end,
    output logic                    o_sample,
    output cnt_pkg::cnt_seg_t       o_seg
);
    logic [5:0]        pre_q,  pre_d;
    logic [3:0]        tq_q,   tq_d;
    cnt_pkg::cnt_seg_t seg_q,  seg_d;
    logic              end_q,  end_d;
    logic              smp_q,  smp_d;
    logic              tick;

    always_comb begin
        pre_d = pre_q;
        tq_d  = tq_q;
        seg_d = seg_q;
        end_d = 1'b0;
        smp_d = 1'b0;
        tick  = 1'b0;
        if (!i_run) begin
            // Hold at sync so a re-enable starts a clean bit
            pre_d = 6'h00;
            tq_d  = 4'h0;
            seg_d = cnt_pkg::SEG_SYNC;
        end else if (pre_q >= i_timing.quantum_divisor) begin
            pre_d = 6'h00;
            tick  = 1'b1;
        end else begin
            pre_d = pre_q + 6'h01;
        end
        if (tick) begin
            case (seg_q)
                cnt_pkg::SEG_SYNC: begin
                    seg_d = cnt_pkg::SEG_FIRST;
                    tq_d  = 4'h0;
                end
                cnt_pkg::SEG_FIRST: begin
                    if (tq_q >= i_timing.first_segment_quanta) begin
                        seg_d = cnt_pkg::SEG_SECND;
                        tq_d  = 4'h0;
                        smp_d = 1'b1;
                    end else begin
                        tq_d = tq_q + 4'h1;
                    end
                end
                cnt_pkg::SEG_SECND: begin
                    if (tq_q >= {1'b0, i_timing.second_segment_quanta}) begin
                        seg_d = cnt_pkg::SEG_SYNC;
                        tq_d  = 4'h0;
                        end_d = 1'b1;
                    end else begin
                        tq_d = tq_q + 4'h1;
                    end
                end
                default: seg_d = cnt_pkg::SEG_SYNC;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_q <= 6'h00;
            tq_q  <= 4'h0;
            seg_q <= cnt_pkg::SEG_SYNC;
            end_q <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            tq_q  <= tq_d;
            seg_q <= seg_d;
            end_q <= end_d;
            smp_q <= smp_d;
        end
    end

    assign o_bit_end = end_q;
    assign o_sample  = smp_q;
    assign o_seg     = seg_q;
endmodule : cnt_quantum
`default_nettype wire

// *** hw/cnt_ctrl.sv ***
// CAN control: bit timing, enable, error counters and interrupts
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit is first plus second plus three quanta
// - Quantum is module clock over divisor plus one
// - First segment, second segment, jump width programmable
// - Timing reads back bits 14:0 as written, upper bits zero
// - Disable stops bus activity, keeps state
// - Enabled controller sends pending, processes received
// - Reset leaves controller disabled
// - Error register: tx, rx counts, passive flag
// - Clear one source by cause or object
// - Status read clears status interrupt
// - Object readout clears its pending interrupt
// - Only enabled sources raise interrupt
// - Global allow gates every interrupt
// - Object interrupt needs its own enable
// - Error interrupt on bus-off or limit
// - Status interrupt on transfer or bus error
// - Interrupt held until source cleared
// - Cause reads status code or object number
module cnt_ctrl (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire cnt_pkg::cnt_evt_t i_evt,
    output logic                   o_run,
    output logic                   o_bit_end,
    output logic                   o_sample,
    output logic                   o_irq
);
    logic [3:0]         ctrl_q,    ctrl_d;
    logic [31:0]        timing_q,  timing_d;
    logic [7:0]         tec_q,     tec_d;
    logic [8:0]         tec_full;
    logic [7:0]         rec_q,     rec_d;
    logic               boff_q,    boff_d;
    logic [7:0]         sts_q,     sts_d;
    logic               stsint_q,  stsint_d;
    logic               errint_q,  errint_d;
    logic [31:0]        pend_q,    pend_d;
    logic [31:0]        txen_q,    txen_d;
    logic [31:0]        rxen_q,    rxen_d;
    logic [31:0]        rdata_q,   rdata_d;
    logic               irq_q,     irq_d;
    logic               run_q;
    logic               wr_q,      wr_d;
    logic [7:0]         addr_q,    addr_d;
    logic [15:0]        cause;
    logic               obj_hit;
    logic [4:0]         obj_num;
    logic               bit_end;
    logic               sample;
    localparam int      NUM_W = 1;
    logic [NUM_W-1:0]   unused_w;
    cnt_pkg::cnt_seg_t  seg;
    cnt_pkg::cnt_timing_t tim;

    assign tim = cnt_pkg::cnt_timing_t'(timing_q);

    cnt_quantum u_quantum (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_run     (run_q),
        .i_timing  (tim),
        .o_bit_end (bit_end),
        .o_sample  (sample),
        .o_seg     (seg)
    );
    assign unused_w = seg[0];

    // Lowest numbered pending object wins priority
    always_comb begin
        obj_hit = 1'b0;
        obj_num = 5'h00;
        for (int i = cnt_pkg::NUM_OBJ - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                obj_hit = 1'b1;
                obj_num = 5'(i);
            end
        end
        if (stsint_q || errint_q) begin
            cause = cnt_pkg::STATUS_CAUSE;
        end else if (obj_hit) begin
            // Widen before adding so object 31 does not wrap to zero
            cause = {11'h000, obj_num} + 16'h0001;
        end else begin
            cause = 16'h0000;
        end
    end

    assign tec_full = {1'b0, tec_q} + 9'h008;

    always_comb begin
        ctrl_d   = ctrl_q;
        timing_d = timing_q;
        tec_d    = tec_q;
        rec_d    = rec_q;
        boff_d   = boff_q;
        sts_d    = sts_q;
        stsint_d = stsint_q;
        errint_d = errint_q;
        pend_d   = pend_q;
        txen_d   = txen_q;
        rxen_d   = rxen_q;
        rdata_d  = rdata_q;
        wr_d     = 1'b0;
        addr_d   = addr_q;
        // Data phase of a captured write
        if (wr_q) begin
            if (addr_q == cnt_pkg::OFS_CTRL) begin
                ctrl_d = hwdata[3:0];
            end else if (addr_q == cnt_pkg::OFS_TIMING) begin
                timing_d = {17'h00000, hwdata[14:0]};
            end else if (addr_q == cnt_pkg::OFS_CLEAR) begin
                if (hwdata[15:0] == cnt_pkg::STATUS_CAUSE) begin
                    stsint_d = 1'b0;
                    errint_d = 1'b0;
                end else if (hwdata[15:0] >= 16'h0001 && hwdata[15:0] <= 16'h0020) begin
                    pend_d[5'(hwdata[4:0] - 5'h01)] = 1'b0;
                end
            end else if (addr_q == cnt_pkg::OFS_OBJTXEN) begin
                txen_d = hwdata;
            end else if (addr_q == cnt_pkg::OFS_OBJRXEN) begin
                rxen_d = hwdata;
            end
        end
        // Address phase: capture writes, fetch read data
        if (hsel && hready && htrans[1]) begin
            wr_d   = hwrite;
            addr_d = haddr[7:0];
            if (!hwrite) begin
                if (haddr[7:0] == cnt_pkg::OFS_CTRL) begin
                    rdata_d = {28'h0000000, ctrl_q};
                end else if (haddr[7:0] == cnt_pkg::OFS_TIMING) begin
                    rdata_d = timing_q;
                end else if (haddr[7:0] == cnt_pkg::OFS_ERRCNT) begin
                    rdata_d = {16'h0000, rec_q >= cnt_pkg::ERR_PASSIVE_LIM,
                               rec_q[6:0], tec_q};
                end else if (haddr[7:0] == cnt_pkg::OFS_STATUS) begin
                    rdata_d = {24'h000000, sts_q};
                    stsint_d = 1'b0;
                    errint_d = 1'b0;
                    sts_d[cnt_pkg::STS_TXOK_BIT] = 1'b0;
                    sts_d[cnt_pkg::STS_RXOK_BIT] = 1'b0;
                end else if (haddr[7:0] == cnt_pkg::OFS_CAUSE) begin
                    rdata_d = {16'h0000, cause};
                end else if (haddr[7:0] == cnt_pkg::OFS_OBJPEND) begin
                    rdata_d = pend_q;
                end else if (haddr[7:0] == cnt_pkg::OFS_OBJTXEN) begin
                    rdata_d = txen_q;
                end else if (haddr[7:0] == cnt_pkg::OFS_OBJRXEN) begin
                    rdata_d = rxen_q;
                end else begin
                    rdata_d = 32'h00000000;
                end
            end
        end
        if (i_evt.obj_read) begin
            pend_d[i_evt.obj_read_idx] = 1'b0;
        end
        // Engine events other than obj_read count only while enabled; set wins over clear
        if (ctrl_q[cnt_pkg::CTRL_ENABLE_BIT]) begin
            if (i_evt.tx_ok) begin
                sts_d[cnt_pkg::STS_TXOK_BIT] = 1'b1;
                stsint_d = 1'b1;
            end
            if (i_evt.rx_ok) begin
                sts_d[cnt_pkg::STS_RXOK_BIT] = 1'b1;
                stsint_d = 1'b1;
            end
            if (i_evt.lec != 3'h0) begin
                sts_d[2:0] = i_evt.lec;
                stsint_d = 1'b1;
            end
            if (i_evt.obj_done &&
                (txen_q[i_evt.obj_idx] || rxen_q[i_evt.obj_idx])) begin
                pend_d[i_evt.obj_idx] = 1'b1;
            end
            if (i_evt.tx_err_inc) begin
                if (tec_full >= cnt_pkg::BUS_OFF_LIM) begin
                    tec_d  = 8'hFF;
                    boff_d = 1'b1;
                    errint_d = 1'b1;
                end else begin
                    tec_d = tec_full[7:0];
                end
            end else if (i_evt.err_dec && tec_q != 8'h00) begin
                tec_d = tec_q - 8'h01;
            end
            if (i_evt.rx_err_inc && rec_q != 8'hFF) begin
                rec_d = rec_q + 8'h01;
            end else if (i_evt.err_dec && rec_q != 8'h00) begin
                rec_d = rec_q - 8'h01;
            end
            if ((rec_d == cnt_pkg::ERR_PASSIVE_LIM && rec_q != rec_d) ||
                (rec_d == cnt_pkg::ERR_WARN_LIM && rec_q != rec_d) ||
                (tec_d >= cnt_pkg::ERR_WARN_LIM && tec_q < cnt_pkg::ERR_WARN_LIM)) begin
                errint_d = 1'b1;
            end
        end
        sts_d[cnt_pkg::STS_EPASS_BIT] = (rec_d >= cnt_pkg::ERR_PASSIVE_LIM) ||
                                        (tec_d >= cnt_pkg::ERR_PASSIVE_LIM);
        sts_d[cnt_pkg::STS_EWARN_BIT] = (rec_d >= cnt_pkg::ERR_WARN_LIM) ||
                                        (tec_d >= cnt_pkg::ERR_WARN_LIM);
        sts_d[cnt_pkg::STS_BOFF_BIT]  = boff_d;
        // Level request held until the source is cleared
        irq_d = ctrl_d[cnt_pkg::CTRL_IE_BIT] &&
                ((stsint_d && ctrl_d[cnt_pkg::CTRL_SIE_BIT]) ||
                 (errint_d && ctrl_d[cnt_pkg::CTRL_EIE_BIT]) ||
                 (pend_d != 32'h00000000));
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q   <= 4'h0;
            timing_q <= cnt_pkg::TIMING_RESET;
            tec_q    <= 8'h00;
            rec_q    <= 8'h00;
            boff_q   <= 1'b0;
            sts_q    <= 8'h00;
            stsint_q <= 1'b0;
            errint_q <= 1'b0;
            pend_q   <= 32'h00000000;
            txen_q   <= 32'h00000000;
            rxen_q   <= 32'h00000000;
            rdata_q  <= 32'h00000000;
            irq_q    <= 1'b0;
            run_q    <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= 8'h00;
        end else begin
            ctrl_q   <= ctrl_d;
            timing_q <= timing_d;
            tec_q    <= tec_d;
            rec_q    <= rec_d;
            boff_q   <= boff_d;
            sts_q    <= sts_d;
            stsint_q <= stsint_d;
            errint_q <= errint_d;
            pend_q   <= pend_d;
            txen_q   <= txen_d;
            rxen_q   <= rxen_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
            run_q    <= ctrl_d[cnt_pkg::CTRL_ENABLE_BIT];
            wr_q     <= wr_d;
            addr_q   <= addr_d;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign o_run     = run_q;
    assign o_bit_end = bit_end;
    assign o_sample  = sample;
    assign o_irq     = irq_q;
endmodule : cnt_ctrl
`default_nettype wire

// *** test/cnt_ctrl_checker.sv ***
// Port checker for the CAN control block
`timescale 1ns/1ps
`default_nettype none
module cnt_ctrl_checker (
    input wire logic              i_ref_clk,
    input wire logic              i_rst_n,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire cnt_pkg::cnt_evt_t i_evt,
    input wire logic              o_run,
    input wire logic              o_bit_end,
    input wire logic              o_sample,
    input wire logic              o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic        dp_q, wr_q, hv_q, sv_q, take, wdp, twr;
    logic [7:0]  a_q;
    logic [3:0]  ctl_q;
    logic [14:0] tim_q;
    logic [11:0] gap_q, smp_q, qlen, blen;
    assign take = hsel && hready && htrans[1];
    assign wdp  = dp_q && wr_q;
    assign twr  = wdp && a_q == cnt_pkg::OFS_TIMING;
    assign qlen = 12'(tim_q[5:0]) + 12'h001;
    assign blen = qlen * (12'h003 + 12'(tim_q[11:8]) + 12'(tim_q[14:12]));
    // Bit counts are trusted only across whole bits with unchanged timing
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_q  <= 1'b0;
            wr_q  <= 1'b0;
            a_q   <= 8'h00;
            ctl_q <= 4'h0;
            tim_q <= cnt_pkg::TIMING_RESET[14:0];
            gap_q <= 12'h000;
            smp_q <= 12'h000;
            hv_q  <= 1'b0;
            sv_q  <= 1'b0;
        end else begin
            dp_q  <= take;
            wr_q  <= hwrite;
            a_q   <= haddr[7:0];
            if (wdp && a_q == cnt_pkg::OFS_CTRL) ctl_q <= hwdata[3:0];
            if (twr) tim_q <= hwdata[14:0];
            gap_q <= o_bit_end ? 12'h001 : gap_q + 12'h001;
            smp_q <= o_sample ? 12'h001 : smp_q + 12'h001;
            hv_q  <= o_run && !twr && (hv_q || o_bit_end);
            sv_q  <= o_run && !twr && (sv_q || o_sample);
        end
    end
    property p_zero_wait;
        hreadyout && !hresp;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("wait state or error seen");
    property p_run_mirror;
        o_run == ctl_q[0];
    endproperty
    a_run_mirror: assert property (p_run_mirror) else $error("run flag off");
    property p_quiet_off;
        !o_run && !$past(o_run) && !$past(o_run, 2) |-> !o_bit_end && !o_sample;
    endproperty
    a_quiet_off: assert property (p_quiet_off) else $error("bit timing while off");
    property p_gate;
        !ctl_q[1] && !$past(ctl_q[1]) |-> !o_irq;
    endproperty
    a_gate: assert property (p_gate) else $error("irq with global allow clear");
    property p_bit_len;
        o_bit_end && hv_q |-> gap_q == blen;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
    property p_samp;
        o_bit_end && sv_q |-> smp_q == qlen * (12'h001 + 12'(tim_q[14:12]));
    endproperty
    a_samp: assert property (p_samp) else $error("sample point wrong");
    property p_hold;
        $fell(o_irq) |-> dp_q || $past(dp_q) || $past(dp_q, 2)
            || $past(i_evt.obj_read) || $past(i_evt.obj_read, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped by itself");
    property p_stat_irq;
        (i_evt.tx_ok || i_evt.rx_ok || i_evt.lec != 3'h0) && ctl_q[0] && ctl_q[1] && ctl_q[2]
            |-> ##[1:3] o_irq;
    endproperty
    a_stat_irq: assert property (p_stat_irq) else $error("status irq missing");
    property p_rd_stand;
        !$past(take && !hwrite) |-> $stable(hrdata);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    c_irq: cover property (o_irq && ctl_q[1]);
    c_bit: cover property (o_bit_end && hv_q);
    c_clr: cover property ($fell(o_irq));
endmodule : cnt_ctrl_checker
bind cnt_ctrl cnt_ctrl_checker u_cnt_ctrl_checker (.i_ref_clk, .i_rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .i_evt, .o_run,
    .o_bit_end, .o_sample, .o_irq);
`default_nettype wire

// *** test/cnt_engine_model.sv ***
// Far-side model: frames and errors seen on the shared bus
`timescale 1ns/1ps
`default_nettype none
module cnt_engine_model (
    input wire logic              i_ref_clk,
    input wire logic              i_rst_n,
    input wire logic              i_run,
    input wire logic              i_bit_end,
    input wire logic              i_slow,
    input wire logic              i_req,
    input wire cnt_pkg::cnt_evt_t i_req_evt,
    output cnt_pkg::cnt_evt_t     o_evt,
    output logic                  o_done
);
    logic pend_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
            o_evt  <= '0;
            o_done <= 1'b0;
        end else begin
            o_evt  <= '0;
            o_done <= 1'b0;
            if (i_req) pend_q <= 1'b1;
            // Traffic only moves while running; slow mode waits for a bit edge
            if (pend_q && i_run && (i_bit_end || !i_slow)) begin
                o_evt  <= i_req_evt;
                o_done <= 1'b1;
                pend_q <= 1'b0;
            end
        end
    end
endmodule : cnt_engine_model
`default_nettype wire

// *** test/tb_can_timing_enable_irq_ctrl.sv ***
// Testbench for the CAN control block
`timescale 1ns/1ps
`default_nettype none
module tb_can_timing_enable_irq_ctrl;
    logic              i_ref_clk, i_rst_n, hsel, hwrite, hreadyout, hresp;
    logic              o_run, o_bit_end, o_sample, o_irq, req, slow, done;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       haddr, hwdata, hrdata, r, t;
    cnt_pkg::cnt_evt_t evt, req_evt, e;
    integer            seed, mismatches, n_compared, i, a, b, c, gap;
    cnt_ctrl u_cnt_ctrl (.i_ref_clk, .i_rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .i_evt(evt), .o_run,
        .o_bit_end, .o_sample, .o_irq);
    cnt_engine_model u_cnt_engine_model (.i_ref_clk, .i_rst_n, .i_run(o_run),
        .i_bit_end(o_bit_end), .i_slow(slow), .i_req(req), .i_req_evt(req_evt),
        .o_evt(evt), .o_done(done));
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    function automatic int blen(input logic [31:0] v);
        return (v[5:0] + 1) * (3 + v[11:8] + v[14:12]);
    endfunction : blen
    task automatic complete_run();
        $display("Compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, ad};
        hwrite <= w;
        do @(posedge i_ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge i_ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] ad, input string s, input logic [31:0] x);
        bus(1'b0, ad, 32'h0);
        chk(s, x, r);
    endtask : rd
    task automatic ev();
        req     <= 1'b1;
        req_evt <= e;
        slow    <= 1'($random(seed));
        @(posedge i_ref_clk);
        req <= 1'b0;
        do @(posedge i_ref_clk); while (done !== 1'b1);
        repeat (3) @(posedge i_ref_clk);
        e = '0;
    endtask : ev
    task automatic wbit();
        do @(posedge i_ref_clk); while (o_bit_end !== 1'b1);
    endtask : wbit
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        mismatches++;
        complete_run();
    end
    initial begin
        seed = 32'hCCE15B1B;
        {mismatches, n_compared} = '0;
        {i_rst_n, hsel, hwrite, req, slow} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        req_evt = '0;
        e = '0;
        repeat (8) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        chk("run", 32'h0, 32'(o_run));
        rd(cnt_pkg::OFS_CTRL, "ctrl", 32'h0);
        rd(cnt_pkg::OFS_TIMING, "timing", cnt_pkg::TIMING_RESET);
        rd(8'h3C, "unmapped", 32'h0);
        bus(1'b1, cnt_pkg::OFS_OBJTXEN, 32'h0);
        bus(1'b1, cnt_pkg::OFS_OBJRXEN, 32'h0);
        for (i = 0; i < 6; i++) begin
            t = (i == 0) ? 32'h0000_7FFF : 32'($random(seed)) & 32'h0000_7FFF;
            bus(1'b1, cnt_pkg::OFS_TIMING, t);
            rd(cnt_pkg::OFS_TIMING, "timing", t);
        end
        bus(1'b1, cnt_pkg::OFS_CTRL, 32'h1);
        wbit();
        wbit();
        gap = 0;
        do begin
            @(posedge i_ref_clk);
            gap++;
        end while (o_bit_end !== 1'b1);
        chk("bit_len", 32'(blen(t)), 32'(gap));
        bus(1'b1, cnt_pkg::OFS_CTRL, 32'h0);
        repeat (3) @(posedge i_ref_clk);
        gap = 0;
        repeat (3300) begin
            @(posedge i_ref_clk);
            gap += o_bit_end;
        end
        chk("idle_bits", 32'h0, 32'(gap));
        rd(cnt_pkg::OFS_TIMING, "kept", t);
        // Short bits keep the event phases quick
        bus(1'b1, cnt_pkg::OFS_TIMING, cnt_pkg::TIMING_RESET);
        bus(1'b1, cnt_pkg::OFS_CTRL, 32'h7);
        for (i = 0; i < 9; i++) begin
            e.tx_ok = (i == 0);
            e.rx_ok = (i == 1);
            e.lec = (i > 1) ? 3'(i - 1) : 3'h0;
            ev();
            rd(cnt_pkg::OFS_CAUSE, "cause", 32'(cnt_pkg::STATUS_CAUSE));
            chk("held", 32'h1, 32'(o_irq));
            bus(1'b0, cnt_pkg::OFS_STATUS, 32'h0);
            chk("status", (i == 0) ? 32'h8 : (i == 1) ? 32'h10 : i - 1, r & 32'h1F);
            repeat (2) @(posedge i_ref_clk);
            chk("st_clr", 32'h0, 32'(o_irq));
        end
        for (i = 0; i < 3; i++) begin
            bus(1'b1, cnt_pkg::OFS_CTRL, (i == 0) ? 32'h5 : (i == 1) ? 32'h3 : 32'h7);
            e.tx_ok = 1'b1;
            ev();
            if (i == 2) bus(1'b1, cnt_pkg::OFS_CLEAR, 32'(cnt_pkg::STATUS_CAUSE));
            repeat (2) @(posedge i_ref_clk);
            chk("gated", 32'h0, 32'(o_irq));
            bus(1'b0, cnt_pkg::OFS_STATUS, 32'h0);
        end
        a = {$random(seed)} % 31;
        b = a + 1 + {$random(seed)} % (31 - a);
        c = (a != 0) ? 0 : (b == 1) ? 2 : 1;
        bus(1'b1, cnt_pkg::OFS_CTRL, 32'h3);
        bus(1'b1, cnt_pkg::OFS_OBJTXEN, (32'h1 << a) | (32'h1 << b));
        bus(1'b1, cnt_pkg::OFS_OBJRXEN, (32'h1 << a) | (32'h1 << b));
        e.obj_done = 1'b1;
        e.obj_idx = 5'(c);
        ev();
        chk("obj_off", 32'h0, 32'(o_irq));
        bus(1'b1, cnt_pkg::OFS_CLEAR, 32'(c + 1));
        for (i = 0; i < 2; i++) begin
            e.obj_done = 1'b1;
            e.obj_idx = 5'((i == 0) ? b : a);
            ev();
        end
        chk("obj_irq", 32'h1, 32'(o_irq));
        rd(cnt_pkg::OFS_OBJPEND, "pend", (32'h1 << a) | (32'h1 << b));
        rd(cnt_pkg::OFS_CAUSE, "cause", 32'(a + 1));
        bus(1'b1, cnt_pkg::OFS_CLEAR, 32'(a + 1));
        rd(cnt_pkg::OFS_CAUSE, "cause", 32'(b + 1));
        chk("obj_held", 32'h1, 32'(o_irq));
        e.obj_read = 1'b1;
        e.obj_read_idx = 5'(b);
        ev();
        rd(cnt_pkg::OFS_CAUSE, "cause", 32'h0);
        chk("obj_clr", 32'h0, 32'(o_irq));
        bus(1'b1, cnt_pkg::OFS_CTRL, 32'hB);
        for (i = 1; i <= 128; i++) begin
            e.rx_err_inc = 1'b1;
            ev();
            if (i >= 127) begin
                bus(1'b0, cnt_pkg::OFS_ERRCNT, 32'h0);
                chk("rec", (i == 127) ? 32'h7F00 : 32'h8000,
                    r & ((i == 127) ? 32'hFF00 : 32'h8000));
            end
        end
        bus(1'b0, cnt_pkg::OFS_STATUS, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        chk("err_clr", 32'h0, 32'(o_irq));
        for (i = 1; i <= 32; i++) begin
            e.tx_err_inc = 1'b1;
            ev();
            if (i == 12) chk("warn_irq", 32'h1, 32'(o_irq));
            if (i == 12) rd(cnt_pkg::OFS_ERRCNT, "tec", 32'h8060);
            if (i == 12) bus(1'b0, cnt_pkg::OFS_STATUS, 32'h0);
        end
        chk("off_irq", 32'h1, 32'(o_irq));
        bus(1'b0, cnt_pkg::OFS_STATUS, 32'h0);
        chk("bus_off", 32'h80, r & 32'h80);
        e.err_dec = 1'b1;
        ev();
        rd(cnt_pkg::OFS_ERRCNT, "dec", 32'h7FFE);
        complete_run();
    end
endmodule : tb_can_timing_enable_irq_ctrl
`default_nettype wire
